// file: verilog/dit_pkg.sv
package dit_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam int          DIT_ADDR_W             = 12;
  localparam logic [11:0] DIT_TIMER0_CONTROL_OFS = 12'hFA0;
  localparam logic [11:0] DIT_TIMER1_CONTROL_OFS = 12'hFA8;
  localparam logic [11:0] DIT_CH0_COUNT_OFS      = 12'hFA2;
  localparam logic [11:0] DIT_CH0_PERIOD_OFS     = 12'hFA4;
  localparam logic [11:0] DIT_CH1_COUNT_OFS      = 12'hFAA;
  localparam logic [11:0] DIT_CH1_PERIOD_OFS     = 12'hFAC;
  localparam logic [11:0] DIT_OUT_ENABLE_OFS     = 12'hFB0;
  localparam logic [11:0] DIT_IRQ_FLAGS_OFS      = 12'hFB2;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         DIT_SEL_MSB     = 6;
  localparam int         DIT_SEL_LSB     = 4;
  localparam int         DIT_START_BIT   = 3;
  localparam int         DIT_RUN_BIT     = 2;
  localparam logic [7:0] DIT_CONTROL_RST = 8'h00;
  localparam logic [7:0] DIT_PERIOD_RST  = 8'hFF;
  localparam logic [7:0] DIT_COUNT_RST   = 8'h00;

  // ----------------------------------------------------------------------
  // Count pulse selection codes and divider exponents
  // ----------------------------------------------------------------------
  localparam logic [2:0] DIT_SEL_EXT_RISE = 3'h0;
  localparam logic [2:0] DIT_SEL_EXT_FALL = 3'h1;
  localparam logic [2:0] DIT_SEL_DIV_A    = 3'h4;
  localparam logic [2:0] DIT_SEL_DIV_B    = 3'h5;
  localparam logic [2:0] DIT_SEL_DIV_C    = 3'h6;
  localparam logic [2:0] DIT_SEL_DIV_D    = 3'h7;
  localparam int         DIT_CH0_EXP_A    = 10;
  localparam int         DIT_CH0_EXP_B    = 8;
  localparam int         DIT_CH0_EXP_C    = 6;
  localparam int         DIT_CH0_EXP_D    = 4;
  localparam int         DIT_CH1_EXP_A    = 12;
  localparam int         DIT_CH1_EXP_B    = 10;
  localparam int         DIT_CH1_EXP_C    = 8;
  localparam int         DIT_CH1_EXP_D    = 6;
  localparam int         DIT_DIV_W        = 12;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int DIT_READ_HOLD_CYCLES = 1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [DIT_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
  } dit_bus_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       start;
    logic       run;
  } dit_ctrl_t;

endpackage : dit_pkg

// file: verilog/dit_prescaler.sv
`timescale 1ns/1ps
module dit_prescaler
  import dit_pkg::*;
#(
  parameter int DIV_W = DIT_DIV_W
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  output logic      [DIV_W:1]   tick
);

  logic [DIV_W-1:0] div_reg;

  // Free running divider shared by both channels
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // One-cycle pulse every 2^k clocks
  for (genvar k = 1; k <= DIV_W; k++) begin : g_tick
    assign tick[k] = &div_reg[k-1:0];
  end

endmodule : dit_prescaler

// file: verilog/dit_event_sync.sv
`timescale 1ns/1ps
module dit_event_sync (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic eventIn,
  output logic      riseEdge,
  output logic      fallEdge
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= eventIn;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  assign riseEdge = sync2_reg & ~last_reg;
  assign fallEdge = ~sync2_reg & last_reg;

endmodule : dit_event_sync

// file: verilog/dual_interval_event_timer.sv
// How it works
// - Channel 0 selects edges or four dividers
// - Channel 1 selects only four internal dividers
// - Start clears count and flag, then counts if run is high
// - Start bit clears itself after starting
// - Run low freezes count, high counts
// - Reset clears both mode registers
// - Count equals period: match sets flag
// - Each match inverts the output toggle
// - Start forces output toggle to zero
// - Output enable gates toggle onto pin
// - Reset clears enables and toggles
// - Interval is period plus one pulses
// - Matches repeat without software action
// - Period register is eight bits wide
// - Only channel 0 counts external edges
// - Period below count: run to overflow
// - Count read holds pulses one cycle
// - Pulse selection change acts at once
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module dual_interval_event_timer
  import dit_pkg::*;
#(
  parameter int DIV_W = DIT_DIV_W
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire dit_bus_t   busReq,
  output logic      [7:0] rdData,
  input  wire logic       externalEventInput,
  output logic            ch0WavePin,
  output logic            ch1WavePin,
  output logic            ch0MatchIrqFlag,
  output logic            ch1MatchIrqFlag
);

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  function automatic logic [DIT_ADDR_W-1:0] ctrlOfs(input int ch);
    ctrlOfs = (ch == 0) ? DIT_TIMER0_CONTROL_OFS : DIT_TIMER1_CONTROL_OFS;
  endfunction : ctrlOfs

  function automatic logic [DIT_ADDR_W-1:0] countOfs(input int ch);
    countOfs = (ch == 0) ? DIT_CH0_COUNT_OFS : DIT_CH1_COUNT_OFS;
  endfunction : countOfs

  function automatic logic [DIT_ADDR_W-1:0] periodOfs(input int ch);
    periodOfs = (ch == 0) ? DIT_CH0_PERIOD_OFS : DIT_CH1_PERIOD_OFS;
  endfunction : periodOfs

  // Decodes a selection code into this cycle's count pulse
  function automatic logic pulseOf(input int ch, input logic [2:0] sel,
                                   input logic [DIV_W:1] tk,
                                   input logic rise, input logic fall);
    logic p;
    p = 1'b0;
    if (ch == 0) begin
      unique case (sel)
        DIT_SEL_EXT_RISE: p = rise;
        DIT_SEL_EXT_FALL: p = fall;
        DIT_SEL_DIV_A:    p = tk[DIT_CH0_EXP_A];
        DIT_SEL_DIV_B:    p = tk[DIT_CH0_EXP_B];
        DIT_SEL_DIV_C:    p = tk[DIT_CH0_EXP_C];
        DIT_SEL_DIV_D:    p = tk[DIT_CH0_EXP_D];
        default:          p = 1'b0;
      endcase
    end else begin
      unique case (sel)
        DIT_SEL_DIV_A:    p = tk[DIT_CH1_EXP_A];
        DIT_SEL_DIV_B:    p = tk[DIT_CH1_EXP_B];
        DIT_SEL_DIV_C:    p = tk[DIT_CH1_EXP_C];
        DIT_SEL_DIV_D:    p = tk[DIT_CH1_EXP_D];
        // Edge codes are refused here: no external path to channel 1
        default:          p = 1'b0;
      endcase
    end
    pulseOf = p;
  endfunction : pulseOf

  // Count after one pulse: wrap after match, free overflow otherwise
  function automatic logic [7:0] nextCount(input logic [7:0] cnt,
                                           input logic [7:0] per);
    if (cnt == per) begin
      nextCount = DIT_COUNT_RST;
    end else begin
      nextCount = cnt + 8'h01;
    end
  endfunction : nextCount

  // ----------------------------------------------------------------------
  // Pulse sources
  // ----------------------------------------------------------------------
  logic [DIV_W:1] tick;
  logic           extRise;
  logic           extFall;

  dit_prescaler #(
    .DIV_W (DIV_W)
  ) u_prescaler (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (tick)
  );

  dit_event_sync u_event_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .eventIn  (externalEventInput),
    .riseEdge (extRise),
    .fallEdge (extFall)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dit_ctrl_t  ctrl_reg    [2];
  logic [7:0] count_reg   [2];
  logic [7:0] period_reg  [2];
  logic [1:0] irq_reg;
  logic [1:0] toggle_reg;
  logic [1:0] outEn_reg;
  logic [1:0] cpPend_reg;
  logic [1:0] wave_reg;
  logic [7:0] rdData_reg;

  // ----------------------------------------------------------------------
  // Decode and per-channel strobes
  // ----------------------------------------------------------------------
  logic [1:0] ctrlWr;
  logic [1:0] periodWr;
  logic [1:0] countHold;
  logic [1:0] cp;
  logic [1:0] cpTake;
  logic [1:0] match_next;
  logic [1:0] doStart;
  logic       outEnWr;
  logic       irqWr;

  assign outEnWr = busReq.wr && (busReq.addr == DIT_OUT_ENABLE_OFS);
  assign irqWr   = busReq.wr && (busReq.addr == DIT_IRQ_FLAGS_OFS);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ctrlWr[i]    = busReq.wr && (busReq.addr == ctrlOfs(i));
      periodWr[i]  = busReq.wr && (busReq.addr == periodOfs(i));
      // A count read freezes the counter for this cycle
      countHold[i] = busReq.rd && (busReq.addr == countOfs(i));
      // Live selection: a new code steers the very next pulse
      cp[i]        = pulseOf(i, ctrl_reg[i].sel, tick,
                             extRise, extFall);
      doStart[i]   = ctrl_reg[i].start;
      cpTake[i]    = ctrl_reg[i].run && !doStart[i] && !countHold[i]
                     && (cp[i] || cpPend_reg[i]);
      match_next[i] = cpTake[i]
                      && (nextCount(count_reg[i], period_reg[i])
                          == period_reg[i]);
    end
  end

  // ----------------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------------
  // Start is held one cycle, carried out, then dropped by itself
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ctrlWr[i]) begin
          ctrl_reg[i].sel   <= busReq.wdata[DIT_SEL_MSB:DIT_SEL_LSB];
          ctrl_reg[i].run   <= busReq.wdata[DIT_RUN_BIT];
          ctrl_reg[i].start <= busReq.wdata[DIT_START_BIT];
        end else if (doStart[i]) begin
          ctrl_reg[i].start <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Period registers
  // ----------------------------------------------------------------------
  // Zero is accepted but makes no sense as a period
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        period_reg[i] <= DIT_PERIOD_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (periodWr[i]) begin
          period_reg[i] <= busReq.wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Held-off pulse
  // ----------------------------------------------------------------------
  // A pulse that lands on a read is applied in the next cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cpPend_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (doStart[i] || !ctrl_reg[i].run) begin
          cpPend_reg[i] <= 1'b0;
        end else if (countHold[i]) begin
          cpPend_reg[i] <= cp[i] || cpPend_reg[i];
        end else begin
          cpPend_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Count registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 2; i++) begin
        count_reg[i] <= DIT_COUNT_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (doStart[i]) begin
          count_reg[i] <= DIT_COUNT_RST;
        end else if (cpTake[i]) begin
          count_reg[i] <= nextCount(count_reg[i], period_reg[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Match flags
  // ----------------------------------------------------------------------
  // A match in the clearing cycle survives, so no event is lost
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (match_next[i]) begin
          irq_reg[i] <= 1'b1;
        end else if (doStart[i] || (irqWr && busReq.wdata[i])) begin
          irq_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output toggles and enables
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      toggle_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (doStart[i]) begin
          toggle_reg[i] <= 1'b0;
        end else if (match_next[i]) begin
          toggle_reg[i] <= ~toggle_reg[i];
        end
      end
    end
  end

  // Port setup before enabling is left to software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      outEn_reg <= 2'h0;
    end else if (outEnWr) begin
      outEn_reg <= busReq.wdata[1:0];
    end
  end

  // Pins lag the toggle by one clock so they leave a flop
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wave_reg <= 2'h0;
    end else begin
      wave_reg <= outEn_reg & toggle_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_reg <= 8'h00;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        DIT_TIMER0_CONTROL_OFS:
          rdData_reg <= {1'b0, ctrl_reg[0].sel, ctrl_reg[0].start,
                         ctrl_reg[0].run, 2'b00};
        DIT_TIMER1_CONTROL_OFS:
          rdData_reg <= {1'b0, ctrl_reg[1].sel, ctrl_reg[1].start,
                         ctrl_reg[1].run, 2'b00};
        DIT_CH0_COUNT_OFS:  rdData_reg <= count_reg[0];
        DIT_CH1_COUNT_OFS:  rdData_reg <= count_reg[1];
        DIT_CH0_PERIOD_OFS: rdData_reg <= period_reg[0];
        DIT_CH1_PERIOD_OFS: rdData_reg <= period_reg[1];
        DIT_OUT_ENABLE_OFS: rdData_reg <= {6'h00, outEn_reg};
        DIT_IRQ_FLAGS_OFS:  rdData_reg <= {6'h00, irq_reg};
        // Unmapped addresses read as zero
        default:            rdData_reg <= 8'h00;
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdData          = rdData_reg;
  assign ch0WavePin      = wave_reg[0];
  assign ch1WavePin      = wave_reg[1];
  assign ch0MatchIrqFlag = irq_reg[0];
  assign ch1MatchIrqFlag = irq_reg[1];

endmodule : dual_interval_event_timer

// file: tb/dit_chk.sv
`timescale 1ns/1ps
module dit_chk
  import dit_pkg::*;
#(
  parameter int DIV_W = DIT_DIV_W
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire dit_bus_t   busReq,
  input wire logic [7:0] rdData,
  input wire logic       externalEventInput,
  input wire logic       ch0WavePin,
  input wire logic       ch1WavePin,
  input wire logic       ch0MatchIrqFlag,
  input wire logic       ch1MatchIrqFlag
);
  // --------
  // Decodes
  // --------
  logic st0;
  logic st1;
  logic en0Wr;
  logic modeRd;
  assign st0 = busReq.wr && busReq.addr == DIT_TIMER0_CONTROL_OFS && busReq.wdata[3];
  assign st1 = busReq.wr && busReq.addr == DIT_TIMER1_CONTROL_OFS && busReq.wdata[3];
  assign en0Wr = busReq.wr && busReq.addr == DIT_OUT_ENABLE_OFS && busReq.wdata[0];
  assign modeRd = busReq.rd && (busReq.addr == DIT_TIMER0_CONTROL_OFS ||
                                busReq.addr == DIT_TIMER1_CONTROL_OFS);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_rstOut;
    $rose(resetn) |-> !ch0WavePin && !ch1WavePin && !ch0MatchIrqFlag && !ch1MatchIrqFlag;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("outputs not idle after reset");
  property p_rdIdle;
    !$past(busReq.rd) |-> rdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  property p_modeMask;
    modeRd |=> rdData[7] == 1'b0 && rdData[1:0] == 2'h0;
  endproperty
  a_modeMask: assert property (p_modeMask) else $error("unused mode bits set");
  property p_startBit;
    busReq.rd && busReq.addr == DIT_TIMER0_CONTROL_OFS && !$past(busReq.wr) |=> !rdData[3];
  endproperty
  a_startBit: assert property (p_startBit) else $error("start bit stuck");
  // Start runs one cycle after the write, so the flag is looked at two edges on
  property p_startClr0;
    st0 |-> ##2 !ch0MatchIrqFlag;
  endproperty
  a_startClr0: assert property (p_startClr0) else $error("start left flag 0");
  property p_startClr1;
    st1 |-> ##2 !ch1MatchIrqFlag;
  endproperty
  a_startClr1: assert property (p_startClr1) else $error("start left flag 1");
  property p_startPin0;
    st0 |-> ##3 !ch0WavePin;
  endproperty
  a_startPin0: assert property (p_startPin0) else $error("start left pin 0 high");
  property p_pinCause0;
    $rose(ch0WavePin) |-> $past(ch0MatchIrqFlag) || $past(en0Wr, 2);
  endproperty
  a_pinCause0: assert property (p_pinCause0) else $error("pin 0 rose uncaused");

  c_flag0: cover property ($rose(ch0MatchIrqFlag));
  c_flag1: cover property ($rose(ch1MatchIrqFlag));
  c_pin0: cover property ($rose(ch0WavePin));
endmodule : dit_chk

bind dual_interval_event_timer dit_chk #(.DIV_W(DIV_W)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .busReq(busReq), .rdData(rdData),
  .externalEventInput(externalEventInput), .ch0WavePin(ch0WavePin),
  .ch1WavePin(ch1WavePin), .ch0MatchIrqFlag(ch0MatchIrqFlag),
  .ch1MatchIrqFlag(ch1MatchIrqFlag)
);

// file: tb/dit_event_src.sv
`timescale 1ns/1ps
module dit_event_src (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       goReq,
  input  wire logic [7:0] pulseNum,
  input  wire logic [3:0] halfLen,
  input  wire logic       wavePin,
  output logic            eventLine,
  output logic            busy,
  output logic [7:0]      waveRises
);
  logic [7:0] left;
  logic [3:0] phase;
  logic       wavePrev;
  assign busy = left != 8'h00;
  // Line idles low; halfLen sets fast or slow pulses
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      left <= 8'h00;
      phase <= 4'h0;
      eventLine <= 1'b0;
    end else if (goReq && !busy) begin
      left <= pulseNum;
      phase <= 4'h0;
    end else if (busy) begin
      phase <= phase + 4'h1;
      if (phase == halfLen) begin
        phase <= 4'h0;
        eventLine <= !eventLine;
        if (eventLine) left <= left - 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wavePrev <= 1'b0;
      waveRises <= 8'h00;
    end else begin
      wavePrev <= wavePin;
      if (wavePin && !wavePrev) waveRises <= waveRises + 8'h01;
    end
  end
endmodule : dit_event_src

// file: tb/test_dual_interval_event_timer.sv
`timescale 1ns/1ps
module test_dual_interval_event_timer
  import dit_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  dit_bus_t   busReq = '0;
  logic [7:0] rdData;
  logic       evLine;
  logic       ch0Wave;
  logic       ch1Wave;
  logic       flag0;
  logic       flag1;
  logic       goReq = 1'b0;
  logic [7:0] pulseNum = 8'h00;
  logic [3:0] halfLen = 4'h1;
  logic       srcBusy;
  logic [7:0] waveRises;
  logic [7:0] v;
  logic [7:0] c1;
  int         failCount = 0;
  int         totalChecks = 0;
  int         cyc = 0;
  int         n;
  int         ex0[4] = '{DIT_CH0_EXP_A, DIT_CH0_EXP_B, DIT_CH0_EXP_C, DIT_CH0_EXP_D};
  int         ex1[4] = '{DIT_CH1_EXP_A, DIT_CH1_EXP_B, DIT_CH1_EXP_C, DIT_CH1_EXP_D};

  always #12.5 core_clk = ~core_clk;

  dual_interval_event_timer #(.DIV_W(DIT_DIV_W)) dut (
    .core_clk(core_clk), .resetn(resetn), .busReq(busReq), .rdData(rdData),
    .externalEventInput(evLine), .ch0WavePin(ch0Wave), .ch1WavePin(ch1Wave),
    .ch0MatchIrqFlag(flag0), .ch1MatchIrqFlag(flag1));
  dit_event_src src (
    .core_clk(core_clk), .resetn(resetn), .goReq(goReq), .pulseNum(pulseNum),
    .halfLen(halfLen), .wavePin(ch0Wave), .eventLine(evLine), .busy(srcBusy),
    .waveRises(waveRises));

  // ----------
  // Bus and compare
  // ----------
  task automatic reportAndStop();
    if (failCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : reportAndStop
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    chk32({24'h0, got}, {24'h0, exp});
  endtask : chkv
  task automatic chkb(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chkb
  // Read data is sampled at the edge after the strobe, before it drops back
  task automatic busOp(input logic w, input logic [11:0] a, input logic [7:0] d);
    busReq <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge core_clk);
    busReq <= '0;
    @(posedge core_clk);
    v = rdData;
  endtask : busOp
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    busOp(1'b0, a, 8'h00);
    chkv(v, e);
  endtask : rdc
  task automatic waitFlag(input int ch, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((ch ? flag1 : flag0) !== 1'b1 && k < 20000);
  endtask : waitFlag
  task automatic meas(input int ch, input logic [2:0] code, input int ex, input logic [7:0] per);
    logic [11:0] base;
    int          k;
    base = ch ? DIT_TIMER1_CONTROL_OFS : DIT_TIMER0_CONTROL_OFS;
    busOp(1'b1, base + 12'h004, per);
    busOp(1'b1, base, {1'b0, code, 4'hC});
    waitFlag(ch, k);
    busOp(1'b1, DIT_IRQ_FLAGS_OFS, ch ? 8'h02 : 8'h01);
    chkb(ch ? ch1Wave : ch0Wave, ch != 0 || code != DIT_SEL_DIV_A);
    waitFlag(ch, k);
    chk32(k + 2, (int'(per) + 1) << ex);
  endtask : meas
  task automatic pulses(input logic [7:0] k, input logic [3:0] h);
    int t;
    pulseNum <= k;
    halfLen <= h;
    goReq <= 1'b1;
    @(posedge core_clk);
    goReq <= 1'b0;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (srcBusy && t < 500);
    // Edge needs three clocks through the synchroniser
    repeat (6) @(posedge core_clk);
  endtask : pulses

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failCount++;
      reportAndStop();
    end
  end

  // ----------
  // Tests
  // ----------
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chkv({4'h0, ch0Wave, ch1Wave, flag0, flag1}, 8'h00);
    rdc(DIT_TIMER0_CONTROL_OFS, 8'h00);
    rdc(DIT_TIMER1_CONTROL_OFS, 8'h00);
    rdc(DIT_OUT_ENABLE_OFS, 8'h00);
    rdc(DIT_CH0_PERIOD_OFS, 8'hFF);
    rdc(DIT_CH1_COUNT_OFS, 8'h00);
    rdc(12'hFB4, 8'h00);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'hFF);
    rdc(DIT_TIMER0_CONTROL_OFS, 8'h74);
    foreach (ex0[i]) begin
      if (i == 1) busOp(1'b1, DIT_OUT_ENABLE_OFS, 8'h03);
      meas(0, 3'h4 + 3'(i), ex0[i], i == 3 ? 8'hFF : 8'h01);
    end
    chkv(waveRises, 8'h03);
    foreach (ex1[i]) meas(1, 3'h4 + 3'(i), ex1[i], 8'h01);
    busOp(1'b1, DIT_CH0_PERIOD_OFS, 8'h80);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h7C);
    repeat (800) @(posedge core_clk);
    busOp(1'b1, DIT_CH0_PERIOD_OFS, 8'h05);
    repeat (200) @(posedge core_clk);
    chkb(flag0, 1'b0);
    waitFlag(0, n);
    chkb(n > 1000 && n < 20000, 1'b1);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h70);
    busOp(1'b0, DIT_CH0_COUNT_OFS, 8'h00);
    c1 = v;
    repeat (40) @(posedge core_clk);
    rdc(DIT_CH0_COUNT_OFS, c1);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h74);
    repeat (40) @(posedge core_clk);
    busOp(1'b0, DIT_CH0_COUNT_OFS, 8'h00);
    chkb(v != c1, 1'b1);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h78);
    repeat (50) @(posedge core_clk);
    rdc(DIT_CH0_COUNT_OFS, 8'h00);
    chkb(flag0, 1'b0);
    busOp(1'b1, DIT_CH0_PERIOD_OFS, 8'h04);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h0C);
    pulses(8'h03, 4'h1);
    rdc(DIT_CH0_COUNT_OFS, 8'h03);
    busOp(1'b1, DIT_TIMER0_CONTROL_OFS, 8'h1C);
    pulses(8'h05, 4'h5);
    rdc(DIT_CH0_COUNT_OFS, 8'h00);
    chkb(flag0, 1'b1);
    rdc(DIT_IRQ_FLAGS_OFS, 8'h03);
    busOp(1'b1, DIT_CH1_PERIOD_OFS, 8'h02);
    busOp(1'b1, DIT_TIMER1_CONTROL_OFS, 8'h0C);
    pulses(8'h04, 4'h1);
    rdc(DIT_CH1_COUNT_OFS, 8'h00);
    reportAndStop();
  end
endmodule : test_dual_interval_event_timer
